// ==== tlf_pkg.sv ====
// Shared constants, codes and helpers for the trigger link framing ends
package tlf_pkg;
    // Line rates in Mb/s and the bunch clock in MHz
    localparam int IN_MBPS_LO = 11200;
    localparam int IN_MBPS_HI = 12800;
    localparam int OPT_MBPS = 6400;
    localparam int OPT_SPARE_MBPS = 12800;
    localparam int ELEC_MBPS = 80;
    localparam int BC_MHZ = 40;
    localparam int OPT_LANES_MAX = 48;
    localparam int OPT_LANES_DEV = OPT_LANES_MAX / 2;
    localparam int WORD_W = 32;
    localparam int FRAME_BITS_LO = 224;
    localparam int FRAME_BITS_HI = 256;
    localparam int PAY_LO_W = FRAME_BITS_LO - 16;
    localparam int PAY_HI_W = FRAME_BITS_HI - 16;
    localparam logic [3:0] LAST_LO = 4'(FRAME_BITS_LO / WORD_W - 1);
    localparam logic [3:0] LAST_HI = 4'(FRAME_BITS_HI / WORD_W - 1);
    localparam int TRIG_W = 32;
    localparam int OVF_W = 16;
    localparam int ELEC_SLOTS = ELEC_MBPS / BC_MHZ;
    localparam int ELEC_LINES = (TRIG_W + OVF_W) / ELEC_SLOTS;
    localparam int BCC_W = 24;
    localparam int OPT_BCC_W = 12;
    localparam logic [1:0] OPT_LAST = 2'h3;
    // Control characters carried with their k flag set
    localparam logic [7:0] K_ALIGN = 8'hBC;
    localparam logic [7:0] K_FILL = 8'h3C;
    localparam logic [7:0] K_DEBUG = 8'hFC;
    localparam logic [3:0] K_START = 4'h8;
    localparam logic [3:0] K_IDLE = 4'hF;
    localparam logic [3:0] K_NONE = 4'h0;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'hFF;
    localparam logic [4:0] STARTUP_WORDS = 5'h10;

    function automatic logic [7:0] crc8_byte(input logic [7:0] c,
                                             input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    // Bytes are taken from the most significant end
    function automatic logic [7:0] crc8_bytes(input logic [7:0] c,
                                              input logic [31:0] w,
                                              input int nb);
        logic [7:0] r;
        r = c;
        for (int i = 0; i < 4; i++) begin
            if (i < nb) begin
                r = crc8_byte(r, w[31 - 8 * i -: 8]);
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] k_match(input logic [31:0] w,
                                           input logic [3:0] k,
                                           input logic [7:0] code);
        logic [3:0] m;
        m = 4'h0;
        for (int i = 0; i < 4; i++) begin
            m[i] = k[i] && (w[8 * i +: 8] == code);
        end
        return m;
    endfunction

    function automatic logic [31:0] put_bytes(input logic [31:0] w,
                                              input logic [3:0] m,
                                              input logic [7:0] v);
        logic [31:0] r;
        r = w;
        for (int i = 0; i < 4; i++) begin
            if (m[i]) begin
                r[8 * i +: 8] = v;
            end
        end
        return r;
    endfunction
endpackage

// ==== tlf_link_if.sv ====
// Link wires between the topology processor and its far-end partners
`timescale 1ns/1ps
interface tlf_link_if;
    logic [31:0] lane_data;
    logic [3:0] lane_k;
    logic [31:0] opt_data;
    logic [3:0] opt_k;
    logic [tlf_pkg::ELEC_LINES-1:0] elec_data;
    logic elec_par;
    logic elec_clk;

    modport dev (
        input lane_data,
        input lane_k,
        output opt_data,
        output opt_k,
        output elec_data,
        output elec_par,
        output elec_clk
    );

    modport far (
        output lane_data,
        output lane_k,
        input opt_data,
        input opt_k,
        input elec_data,
        input elec_par,
        input elec_clk
    );
endinterface

// ==== tlf_topo_end.sv ====
// Topology processor end: input lane receiver and trigger output framing
`timescale 1ns/1ps
module tlf_topo_end (
    input logic clk_i,
    input logic reset_n_i,
    tlf_link_if.dev link,
    input logic quad_rate_hi_i,
    input logic err_clear_i,
    input logic [tlf_pkg::TRIG_W-1:0] trig_i,
    input logic [tlf_pkg::OVF_W-1:0] ovf_i,
    input logic elec_aux_en_i,
    output logic [tlf_pkg::FRAME_BITS_HI-1:0] rx_payload_o,
    output logic rx_valid_o,
    output logic [tlf_pkg::BCC_W-1:0] rx_bcc_o,
    output logic rx_bcc_valid_o,
    output logic crc_err_o,
    output logic comma_err_o,
    output logic lane_err_o
);
    typedef enum logic {RX_HUNT, RX_FRAME} tlf_rx_t;

    localparam int SNAP_W = tlf_pkg::TRIG_W + tlf_pkg::OVF_W;
    localparam int EL = tlf_pkg::ELEC_LINES;

    tlf_rx_t rx_state_reg;
    logic [3:0] idx_reg;
    logic [7:0] crc_reg;
    logic rate_reg;
    logic [tlf_pkg::FRAME_BITS_HI-1:0] pay_reg;
    logic valid_reg;
    logic [tlf_pkg::BCC_W-1:0] bcc_reg;
    logic bcc_valid_reg;
    logic crc_err_reg;
    logic comma_err_reg;
    logic lane_err_reg;

    logic [1:0] ow_reg;
    logic [tlf_pkg::OPT_BCC_W-1:0] bcc_tx_reg;
    logic [SNAP_W-1:0] snap_reg;
    logic [7:0] crc_tx_reg;
    logic [31:0] opt_data_reg;
    logic [3:0] opt_k_reg;
    logic [EL-1:0] elec_data_reg;
    logic elec_par_reg;
    logic elec_clk_reg;

    // Receive decoding
    wire [31:0] d = link.lane_data;
    wire [3:0] k = link.lane_k;
    wire [3:0] align_m = tlf_pkg::k_match(d, k, tlf_pkg::K_ALIGN);
    wire [3:0] fill_m = tlf_pkg::k_match(d, k, tlf_pkg::K_FILL);
    // Filler commas stand for zero data bytes
    wire [31:0] dec_w = tlf_pkg::put_bytes(d, fill_m, 8'h00);
    // Start word may carry fillers in its three data bytes
    wire start_w = align_m[3] && (k[2:0] == fill_m[2:0]);
    wire idle_w = (k == tlf_pkg::K_IDLE) && (&align_m);
    wire debug_w = (k == tlf_pkg::K_START)
        && (d[31:24] == tlf_pkg::K_DEBUG);
    wire in_frame = (rx_state_reg == RX_FRAME);
    wire [3:0] last_idx = rate_reg ? tlf_pkg::LAST_HI
                                   : tlf_pkg::LAST_LO;
    wire last_w = in_frame && (idx_reg == last_idx);
    // Alignment comma anywhere but word 0, byte 3 breaks the frame
    wire stray_f = in_frame && (|align_m);
    wire stray_h = !in_frame && (|align_m) && !start_w && !idle_w;
    wire comma_set = stray_f || stray_h;
    wire take_w = in_frame && !stray_f;
    wire [7:0] crc_start = tlf_pkg::crc8_bytes(tlf_pkg::CRC_INIT,
                                               dec_w, 4);
    wire [7:0] crc_run = tlf_pkg::crc8_bytes(crc_reg, dec_w,
                                             last_w ? 3 : 4);
    // CRC byte is never filled, so the raw lane byte is compared
    wire crc_set = take_w && last_w && (crc_run != d[7:0]);
    wire done_w = take_w && last_w;
    wire bcc_take = !in_frame && debug_w;

    // Receiver sequencing
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rx_state_reg <= RX_HUNT;
            idx_reg <= 4'h0;
            crc_reg <= tlf_pkg::CRC_INIT;
            rate_reg <= 1'b0;
            pay_reg <= '0;
        end else begin
            case (rx_state_reg)
                RX_HUNT: begin
                    if (start_w) begin
                        rx_state_reg <= RX_FRAME;
                        idx_reg <= 4'h1;
                        crc_reg <= crc_start;
                        // Rate is taken from the lane's quad per frame
                        rate_reg <= quad_rate_hi_i;
                        pay_reg <= {224'h0, dec_w};
                    end
                end
                RX_FRAME: begin
                    if (stray_f || last_w) begin
                        rx_state_reg <= RX_HUNT;
                    end
                    if (take_w) begin
                        idx_reg <= idx_reg + 4'h1;
                        crc_reg <= crc_run;
                        pay_reg <= {pay_reg[223:0], dec_w};
                    end
                end
                default: rx_state_reg <= RX_HUNT;
            endcase
        end
    end

    // Receiver outputs, sticky CRC and comma errors, one-cycle lane error; a new error beats the clear
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            valid_reg <= 1'b0;
            bcc_reg <= '0;
            bcc_valid_reg <= 1'b0;
            crc_err_reg <= 1'b0;
            comma_err_reg <= 1'b0;
            lane_err_reg <= 1'b0;
        end else begin
            valid_reg <= done_w;
            bcc_valid_reg <= bcc_take;
            if (bcc_take) begin
                bcc_reg <= d[23:0];
            end
            crc_err_reg <= crc_set | (crc_err_reg & ~err_clear_i);
            comma_err_reg <= comma_set
                | (comma_err_reg & ~err_clear_i);
            lane_err_reg <= crc_set | comma_set;
        end
    end

    // Optical frame: comma and count, trigger, overflow, CRC.
    // One of OPT_LANES_DEV lanes; its own counter, no bonding.
    wire [31:0] tx_w0 = {tlf_pkg::K_ALIGN, 4'h0, bcc_tx_reg, 8'h00};
    wire [7:0] crc_fin = tlf_pkg::crc8_bytes(crc_tx_reg, 32'h0, 3);
    wire [31:0] tx_word = (ow_reg == 2'h0) ? tx_w0
        : (ow_reg == 2'h1) ? snap_reg[SNAP_W-1 -: 32]
        : (ow_reg == 2'h2) ? {snap_reg[tlf_pkg::OVF_W-1:0], 16'h0000}
        : {24'h000000, crc_fin};
    wire [3:0] tx_k = (ow_reg == 2'h0) ? tlf_pkg::K_START
                                       : tlf_pkg::K_NONE;
    wire [7:0] crc_tx_next = tlf_pkg::crc8_bytes(
        (ow_reg == 2'h0) ? tlf_pkg::CRC_INIT : crc_tx_reg, tx_word, 4);
    wire opt_end = (ow_reg == tlf_pkg::OPT_LAST);
    // Two bit slots per crossing on the electrical lines
    wire [EL-1:0] slot_w = ow_reg[1] ? snap_reg[SNAP_W-1 -: EL]
                                     : snap_reg[EL-1:0];

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ow_reg <= 2'h0;
            bcc_tx_reg <= '0;
            snap_reg <= '0;
            crc_tx_reg <= tlf_pkg::CRC_INIT;
            opt_data_reg <= 32'h0;
            opt_k_reg <= tlf_pkg::K_NONE;
        end else begin
            ow_reg <= ow_reg + 2'h1;
            crc_tx_reg <= crc_tx_next;
            opt_data_reg <= tx_word;
            opt_k_reg <= tx_k;
            if (opt_end) begin
                bcc_tx_reg <= bcc_tx_reg + 12'h001;
                snap_reg <= {trig_i, ovf_i};
            end
        end
    end

    // Parity and clock lines stay low unless enabled
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            elec_data_reg <= '0;
            elec_par_reg <= 1'b0;
            elec_clk_reg <= 1'b0;
        end else begin
            elec_data_reg <= slot_w;
            elec_par_reg <= elec_aux_en_i & (^slot_w);
            elec_clk_reg <= elec_aux_en_i & ~ow_reg[1];
        end
    end

    assign link.opt_data = opt_data_reg;
    assign link.opt_k = opt_k_reg;
    assign link.elec_data = elec_data_reg;
    assign link.elec_par = elec_par_reg;
    assign link.elec_clk = elec_clk_reg;
    assign rx_payload_o = pay_reg;
    assign rx_valid_o = valid_reg;
    assign rx_bcc_o = bcc_reg;
    assign rx_bcc_valid_o = bcc_valid_reg;
    assign crc_err_o = crc_err_reg;
    assign comma_err_o = comma_err_reg;
    assign lane_err_o = lane_err_reg;
endmodule

// ==== tlf_far_end.sv ====
// Far end: feature extractor lane sender and trigger processor receiver
`timescale 1ns/1ps
module tlf_far_end (
    input logic clk_i,
    input logic reset_n_i,
    tlf_link_if.far link,
    input logic link_en_i,
    input logic quad_rate_hi_i,
    input logic [tlf_pkg::PAY_HI_W-1:0] tx_payload_i,
    input logic tx_dbg_req_i,
    input logic elec_aux_en_i,
    output logic tx_frame_o,
    output logic [tlf_pkg::TRIG_W-1:0] ctp_trig_o,
    output logic [tlf_pkg::OVF_W-1:0] ctp_ovf_o,
    output logic [tlf_pkg::OPT_BCC_W-1:0] ctp_bcc_o,
    output logic ctp_valid_o,
    output logic ctp_crc_err_o,
    output logic [2*tlf_pkg::ELEC_LINES-1:0] elec_word_o,
    output logic elec_par_err_o
);
    typedef enum logic [1:0] {TX_SYNC, TX_DBG, TX_FRAME} tlf_tx_t;

    localparam int EL = tlf_pkg::ELEC_LINES;

    tlf_tx_t tx_state_reg;
    logic [4:0] sync_cnt_reg;
    logic [3:0] tidx_reg;
    logic [255:0] img_reg;
    logic trate_reg;
    logic [7:0] tcrc_reg;
    logic [tlf_pkg::BCC_W-1:0] bcc_reg;
    logic dbg_pend_reg;
    logic frame_reg;
    logic [31:0] lane_data_reg;
    logic [3:0] lane_k_reg;

    // Sender framing
    wire [255:0] img_new = quad_rate_hi_i
        ? {tlf_pkg::K_ALIGN, tx_payload_i, 8'h00}
        : {tlf_pkg::K_ALIGN, tx_payload_i[tlf_pkg::PAY_LO_W-1:0],
           8'h00, 32'h0};
    wire [3:0] tlast = trate_reg ? tlf_pkg::LAST_HI : tlf_pkg::LAST_LO;
    wire t_first = (tidx_reg == 4'h0);
    wire t_last = (tidx_reg == tlast);
    wire [31:0] raw_w = img_reg[255:224];
    wire [7:0] crc_fin = tlf_pkg::crc8_bytes(tcrc_reg, raw_w, 3);
    wire [31:0] out_w = t_last ? {raw_w[31:8], crc_fin} : raw_w;
    wire [3:0] dmask = t_first ? 4'h7 : (t_last ? 4'hE : 4'hF);
    wire [3:0] zero_m = tlf_pkg::k_match(out_w, 4'hF, 8'h00) & dmask;
    wire [31:0] fill_w = tlf_pkg::put_bytes(out_w, zero_m,
                                            tlf_pkg::K_FILL);
    wire [3:0] fill_k = (t_first ? tlf_pkg::K_START : tlf_pkg::K_NONE)
        | zero_m;
    wire [7:0] tcrc_next = tlf_pkg::crc8_bytes(
        t_first ? tlf_pkg::CRC_INIT : tcrc_reg, raw_w, 4);
    wire sync_done = (sync_cnt_reg == tlf_pkg::STARTUP_WORDS);
    wire in_tx = (tx_state_reg == TX_FRAME);
    wire in_sync = (tx_state_reg == TX_SYNC);
    wire in_dbg = (tx_state_reg == TX_DBG);
    wire boundary = (in_sync && sync_done && link_en_i)
        || (in_tx && t_last);
    wire go_dbg = boundary && dbg_pend_reg;
    wire go_frame = (boundary && !dbg_pend_reg) || in_dbg;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            tx_state_reg <= TX_SYNC;
            sync_cnt_reg <= 5'h00;
            tidx_reg <= 4'h0;
            img_reg <= '0;
            trate_reg <= 1'b0;
            tcrc_reg <= tlf_pkg::CRC_INIT;
        end else begin
            if (in_sync && link_en_i && !sync_done) begin
                sync_cnt_reg <= sync_cnt_reg + 5'h01;
            end
            if (in_tx) begin
                tidx_reg <= tidx_reg + 4'h1;
                img_reg <= {img_reg[223:0], 32'h0};
                tcrc_reg <= tcrc_next;
            end
            if (go_dbg) begin
                tx_state_reg <= TX_DBG;
            end else if (go_frame) begin
                tx_state_reg <= TX_FRAME;
                tidx_reg <= 4'h0;
                img_reg <= img_new;
                trate_reg <= quad_rate_hi_i;
            end
        end
    end

    // Pending debug request: a new request beats the clear
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            bcc_reg <= '0;
            dbg_pend_reg <= 1'b0;
            frame_reg <= 1'b0;
            lane_data_reg <= 32'h0;
            lane_k_reg <= tlf_pkg::K_NONE;
        end else begin
            dbg_pend_reg <= tx_dbg_req_i | (dbg_pend_reg & ~in_dbg);
            frame_reg <= go_frame;
            if (go_frame) begin
                bcc_reg <= bcc_reg + 24'h000001;
            end
            if (in_tx) begin
                lane_data_reg <= fill_w;
                lane_k_reg <= fill_k;
            end else if (in_dbg) begin
                lane_data_reg <= {tlf_pkg::K_DEBUG, bcc_reg};
                lane_k_reg <= tlf_pkg::K_START;
            end else begin
                lane_data_reg <= {4{tlf_pkg::K_ALIGN}};
                lane_k_reg <= tlf_pkg::K_IDLE;
            end
        end
    end

    // Trigger processor receive side
    logic c_act_reg;
    logic [1:0] c_ow_reg;
    logic [7:0] c_crc_reg;
    logic [tlf_pkg::TRIG_W-1:0] c_trig_reg;
    logic [tlf_pkg::OVF_W-1:0] c_ovf_reg;
    logic [tlf_pkg::OPT_BCC_W-1:0] c_bcc_reg;
    logic c_valid_reg;
    logic c_err_reg;
    logic [EL-1:0] e0_reg;
    logic [2*EL-1:0] e_word_reg;
    logic e_err_reg;

    wire [31:0] od = link.opt_data;
    wire c_start = (link.opt_k == tlf_pkg::K_START)
        && (od[31:24] == tlf_pkg::K_ALIGN);
    wire c_end = c_act_reg && (c_ow_reg == tlf_pkg::OPT_LAST);
    wire c_bad = c_end
        && (tlf_pkg::crc8_bytes(c_crc_reg, od, 3) != od[7:0]);
    wire e_cap = c_act_reg && c_ow_reg[0];
    wire e_bad = e_cap && elec_aux_en_i
        && (link.elec_par != (^link.elec_data));

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            c_act_reg <= 1'b0;
            c_ow_reg <= 2'h0;
            c_crc_reg <= tlf_pkg::CRC_INIT;
            c_trig_reg <= '0;
            c_ovf_reg <= '0;
            c_bcc_reg <= '0;
            c_valid_reg <= 1'b0;
            c_err_reg <= 1'b0;
            e0_reg <= '0;
            e_word_reg <= '0;
            e_err_reg <= 1'b0;
        end else begin
            c_valid_reg <= c_end;
            c_err_reg <= c_bad;
            e_err_reg <= e_bad;
            c_crc_reg <= tlf_pkg::crc8_bytes(
                c_start ? tlf_pkg::CRC_INIT : c_crc_reg, od, 4);
            if (c_start) begin
                c_act_reg <= 1'b1;
                c_ow_reg <= 2'h1;
                c_bcc_reg <= od[19:8];
            end else if (c_act_reg) begin
                c_ow_reg <= c_ow_reg + 2'h1;
                c_act_reg <= !c_end;
            end
            if (c_act_reg && (c_ow_reg == 2'h1)) begin
                c_trig_reg <= od;
                e0_reg <= link.elec_data;
            end
            if (c_act_reg && (c_ow_reg == 2'h2)) begin
                c_ovf_reg <= od[31:16];
            end
            if (c_end) begin
                e_word_reg <= {link.elec_data, e0_reg};
            end
        end
    end

    assign link.lane_data = lane_data_reg;
    assign link.lane_k = lane_k_reg;
    assign tx_frame_o = frame_reg;
    assign ctp_trig_o = c_trig_reg;
    assign ctp_ovf_o = c_ovf_reg;
    assign ctp_bcc_o = c_bcc_reg;
    assign ctp_valid_o = c_valid_reg;
    assign ctp_crc_err_o = c_err_reg;
    assign elec_word_o = e_word_reg;
    assign elec_par_err_o = e_err_reg;
endmodule

// ==== tlf_link_checker.sv ====
// Protocol checker for the link wires between the two ends
`timescale 1ns/1ps
module tlf_link_checker (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [31:0] lane_data,
    input wire logic [3:0] lane_k,
    input wire logic [31:0] opt_data,
    input wire logic [3:0] opt_k,
    input wire logic [23:0] elec_data,
    input wire logic elec_par,
    input wire logic elec_clk
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // Align comma in a low byte is legal only in an idle word
    wire logic low_comma;
    wire logic w0_start;
    assign low_comma = (lane_k[0] && lane_data[7:0] == 8'hBC) ||
                       (lane_k[1] && lane_data[15:8] == 8'hBC) ||
                       (lane_k[2] && lane_data[23:16] == 8'hBC);
    assign w0_start = opt_k == 4'h8;

    a_lane_comma_pos: assert property (
        low_comma |-> lane_k == 4'hF && lane_data == 32'hBCBCBCBC)
        else $error("lane comma outside fixed position");
    a_opt_frame_len: assert property (
        w0_start |=> opt_k == 4'h0 [*3] ##1 w0_start)
        else $error("optical frame not four words");
    a_opt_start_fmt: assert property (
        w0_start |-> opt_data[31:20] == 12'hBC0 && opt_data[7:0] == 8'h00)
        else $error("optical start word malformed");
    a_opt_bcc_step: assert property (
        w0_start |-> ##4
        opt_data[19:8] == $past(opt_data[19:8], 4) + 12'h1)
        else $error("optical bunch count did not step");
    a_opt_pad_zero: assert property (
        w0_start |-> ##2 opt_data[15:0] == 16'h0
        ##1 opt_data[31:8] == 24'h0)
        else $error("optical padding not zero");
    a_elec_slot_hold: assert property (
        w0_start |-> ##1 $stable(elec_data) ##2 $stable(elec_data))
        else $error("electrical slot changed mid slot");
    a_elec_trig_map: assert property (
        w0_start |-> ##2 elec_data == $past(opt_data[31:8]))
        else $error("electrical slot1 differs from trigger bits");
    a_elec_clk_shape: assert property (
        $rose(elec_clk) |=> elec_clk ##1 !elec_clk [*2])
        else $error("electrical clock shape wrong");
    a_elec_par_xor: assert property (
        $rose(elec_clk) |-> elec_par == ^elec_data)
        else $error("electrical parity wrong");

    c_opt_frame: cover property (w0_start ##4 w0_start);
    c_lane_start: cover property (lane_k[3] && lane_data[31:24] == 8'hBC);
    c_lane_debug: cover property (lane_k == 4'h8 && lane_data[31:24] == 8'hFC);
endmodule

// ==== trigger_link_framing_tb_top.sv ====
// Testbench joining both link ends, plus a rule-breaking lane driver
`timescale 1ns/1ps
module trigger_link_framing_tb_top;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic rate_hi = 1'b0, link_en = 1'b0, err_clr = 1'b0, dbg = 1'b0;
    logic [31:0] trig = 32'h0;
    logic [15:0] ovf = 16'h0;
    logic [239:0] pay = 240'h0;
    logic [255:0] pa, pb, p2;
    logic [47:0] ew;
    logic [23:0] bcc;
    logic [11:0] cb, ctp_bcc;
    logic [31:0] ctr;
    logic [15:0] cov;
    logic va, vb, ce_a, me_a, ce_b, me_b, le_b, bv, txf, cv, cce, pe;
    int bad_count = 0, tests_run = 0, cyc = 0, frames = 0;
    tlf_link_if link_a();
    tlf_link_if link_b();

    always #12.5 clk_i = ~clk_i;

    tlf_topo_end i_tlf_topo_end (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .link(link_a), .quad_rate_hi_i(rate_hi), .err_clear_i(err_clr),
        .trig_i(trig), .ovf_i(ovf), .elec_aux_en_i(1'b1),
        .rx_payload_o(pa), .rx_valid_o(va), .rx_bcc_o(bcc),
        .rx_bcc_valid_o(bv), .crc_err_o(ce_a), .comma_err_o(me_a),
        .lane_err_o());
    tlf_far_end i_tlf_far_end (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .link(link_a), .link_en_i(link_en), .quad_rate_hi_i(rate_hi),
        .tx_payload_i(pay), .tx_dbg_req_i(dbg), .elec_aux_en_i(1'b1),
        .tx_frame_o(txf), .ctp_trig_o(ctr), .ctp_ovf_o(cov),
        .ctp_bcc_o(ctp_bcc), .ctp_valid_o(cv), .ctp_crc_err_o(cce),
        .elec_word_o(ew), .elec_par_err_o(pe));
    // Second receiver fed by hand so broken frames can be injected
    tlf_topo_end i_tlf_topo_end_b (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .link(link_b), .quad_rate_hi_i(1'b0), .err_clear_i(err_clr),
        .trig_i(trig), .ovf_i(ovf), .elec_aux_en_i(1'b0),
        .rx_payload_o(pb), .rx_valid_o(vb), .rx_bcc_o(),
        .rx_bcc_valid_o(), .crc_err_o(ce_b), .comma_err_o(me_b),
        .lane_err_o(le_b));
    tlf_link_checker i_tlf_link_checker (.clk_i(clk_i),
        .reset_n_i(reset_n_i), .lane_data(link_a.lane_data),
        .lane_k(link_a.lane_k), .opt_data(link_a.opt_data),
        .opt_k(link_a.opt_k), .elec_data(link_a.elec_data),
        .elec_par(link_a.elec_par), .elec_clk(link_a.elec_clk));

    initial begin
        link_b.lane_data = 32'hBCBCBCBC;
        link_b.lane_k = 4'hF;
    end

    // Sampled before the edge updates land, so no race with the pulse
    always @(posedge clk_i) begin
        cyc++;
        if (!reset_n_i) frames = 0;
        else if (txf === 1'b1) frames++;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end

    function automatic logic [7:0] crc_of(logic [255:0] v, int n);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = n - 1; i >= 0; i--) begin
            c ^= v[8 * i +: 8];
            for (int j = 0; j < 8; j++) c = c[7] ? (c << 1) ^ 8'h07 : c << 1;
        end
        return c;
    endfunction

    task automatic check(logic [255:0] seen, logic [255:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic clear_errors;
        err_clr = 1'b1;
        @(negedge clk_i);
        err_clr = 1'b0;
    endtask

    task automatic wait_rx;
        do @(negedge clk_i); while (va !== 1'b1);
    endtask

    // Hand-built low rate frame; bad selects a word to carry a stray comma
    task automatic send_b(logic [223:0] f, int bad);
        // Idle word of the previous call stands one cycle first
        @(negedge clk_i);
        for (int i = 0; i < 7; i++) begin
            link_b.lane_data = (i == bad) ? {f[223 - 32 * i -: 24], 8'hBC}
                                          : f[223 - 32 * i -: 32];
            link_b.lane_k = (i == bad) ? 4'h1 : (i == 0) ? 4'h8 : 4'h0;
            @(negedge clk_i);
        end
        link_b.lane_data = 32'hBCBCBCBC;
        link_b.lane_k = 4'hF;
    endtask

    initial begin
        logic [255:0] fr;
        logic [223:0] fb;
        repeat (4) @(negedge clk_i);
        reset_n_i = 1'b1;
        link_en = 1'b1;
        // Zero bytes at both ends of the payload travel as fillers
        for (int r = 0; r < 2; r++) begin
            rate_hi = r[0];
            pay = r ? {8'h00, {28{8'hC3}}, 8'h00} :
                      {32'h0, 8'h00, {24{8'h5A}}, 8'h00};
            fr = r ? {8'hBC, pay, 8'h00} : {32'h0, 8'hBC, pay[207:0], 8'h00};
            fr[7:0] = crc_of(fr >> 8, r ? 31 : 27);
            repeat (3) wait_rx;
            clear_errors();
            wait_rx;
            check(pa, fr);
            check({ce_a, me_a}, 2'b00);
        end
        $display("test frames done");
        dbg = 1'b1;
        @(negedge clk_i);
        dbg = 1'b0;
        do @(negedge clk_i); while (bv !== 1'b1);
        // Frame after the debug word is already counted when it lands
        check(bcc, 24'(frames - 1));
        wait_rx;
        check(pa, fr);
        check(me_a, 1'b0);
        $display("test debug done");
        for (int i = 0; i < 2; i++) begin
            trig = i ? 32'h8421F00D : 32'h12345678;
            ovf = i ? 16'hA5C3 : 16'h0F0F;
            repeat (3) do @(negedge clk_i); while (cv !== 1'b1);
            cb = ctp_bcc;
            check({ctr, cov, cce, pe}, {trig, ovf, 2'b00});
            check(ew, {trig, ovf});
            do @(negedge clk_i); while (cv !== 1'b1);
            check(ctp_bcc, 12'(cb + 12'h1));
        end
        $display("test trigger output done");
        fb = {8'hBC, {26{8'h5A}}, 8'h00};
        fb[7:0] = crc_of({32'h0, fb} >> 8, 27);
        send_b(fb, -1);
        check({vb, pb[254:0]}, {1'b1, 31'h0, fb});
        send_b(fb ^ 224'h1, -1);
        // A bad CRC is flagged but the frame is still delivered
        check({vb, le_b, ce_b}, 3'b111);
        clear_errors();
        check(ce_b, 1'b0);
        send_b(fb, 3);
        check({vb, me_b, ce_b}, 3'b010);
        $display("test injected faults done");
        results();
    end
endmodule
